// ===== verilog/tsr_pkg.sv
/*
  Constants shared by the timing signal router: sizes, register offsets,
  field positions, reset values and source codes.
  Assumes a 32-bit plain register port with byte addresses.
*/
package tsr_pkg;

  // ==========================================================================
  // Sizes
  localparam int TSR_NUM_DIO = 8;
  localparam int TSR_NUM_PFI = 10;
  localparam int TSR_NUM_TRIG = 7;
  localparam int TSR_NUM_SIG = 13;
  localparam int TSR_NUM_INT = 4;
  localparam int TSR_NUM_CHAN = 8;
  localparam int TSR_NUM_BUS_SIG = 5;
  localparam int TSR_NUM_SRC = TSR_NUM_TRIG + TSR_NUM_PFI + TSR_NUM_INT;
  localparam int TSR_SEL_W = 5;
  localparam int TSR_TSEL_W = 3;
  localparam int TSR_ADDR_W = 8;
  localparam int TSR_DATA_W = 32;

  // ==========================================================================
  // Clock rates
  localparam int TSR_CORE_CLK_MHZ = 250;
  localparam int TSR_INT_TIMEBASE_MHZ = 20;

  // ==========================================================================
  // Register offsets
  localparam logic [7:0] TSR_OFF_CTRL = 8'h00;
  localparam logic [7:0] TSR_OFF_DIO_DIR = 8'h04;
  localparam logic [7:0] TSR_OFF_DIO_OUT = 8'h08;
  localparam logic [7:0] TSR_OFF_DIO_IN = 8'h0c;
  localparam logic [7:0] TSR_OFF_PFI_OE = 8'h10;
  localparam logic [7:0] TSR_OFF_TRIG_OE = 8'h14;
  localparam logic [7:0] TSR_OFF_TRIG_SEL = 8'h18;
  localparam logic [7:0] TSR_OFF_REF_SEL = 8'h1c;
  localparam logic [7:0] TSR_OFF_REGLITCH = 8'h20;
  localparam logic [7:0] TSR_OFF_STATUS = 8'h24;
  localparam logic [7:0] TSR_OFF_SRC_BASE = 8'h40;

  // ==========================================================================
  // Fields
  localparam int TSR_CTRL_TB_SEL_BIT = 0;
  localparam int TSR_CTRL_TB_DRIVE_BIT = 1;
  localparam logic TSR_TB_INTERNAL = 1'b0;
  localparam logic [9:0] TSR_PFI_OUT_CAPABLE = 10'h378;

  // ==========================================================================
  // Reset values
  localparam logic [1:0] TSR_RST_CTRL = 2'h0;
  localparam logic [7:0] TSR_RST_DIO_DIR = 8'h00;
  localparam logic [7:0] TSR_RST_DIO_OUT = 8'h00;
  localparam logic [9:0] TSR_RST_PFI_OE = 10'h000;
  localparam logic [9:0] TSR_RST_PFI_OUT = 10'h020;
  localparam logic [6:0] TSR_RST_TRIG_OE = 7'h00;
  localparam logic [20:0] TSR_RST_TRIG_SEL = 21'h1fffff;
  localparam logic [7:0] TSR_RST_REF_SEL = 8'h00;
  localparam logic [7:0] TSR_RST_REGLITCH = 8'h00;
  localparam logic [4:0] TSR_RST_SRC_SEL = 5'h1f;

  // ==========================================================================
  // Source codes and signal indices
  localparam logic [4:0] TSR_SRC_TRIG_BASE = 5'h00;
  localparam logic [4:0] TSR_SRC_PFI_BASE = 5'h07;
  localparam logic [4:0] TSR_SRC_INT_BASE = 5'h11;
  localparam int TSR_INT_SAMPLE_TC = 0;
  localparam int TSR_INT_COUNTER_ZERO = 1;
  localparam int TSR_SIG_UPDATE = 0;
  localparam int TSR_SIG_WAVE_START = 1;
  localparam int TSR_SIG_C0_SRC = 2;
  localparam int TSR_SIG_C0_GATE = 3;
  localparam int TSR_SIG_C1_SRC = 4;
  localparam int TSR_SIG_C1_GATE = 5;

endpackage : tsr_pkg

// ===== verilog/tsr_pin_sync.sv
/*
  Three-stage input synchroniser with agreement filter.
  Assumes asynchronous inputs; output moves once stages two and three agree.
*/
`timescale 1ns/1ps
module tsr_pin_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic srst_i,
  // Data
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  wire logic [WIDTH-1:0] differ = stage2 ^ stage3;

  // Stage one feeds stage two only
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
      sync_o <= '0;
    end else begin
      stage1 <= async_i;
      stage2 <= stage1;
      stage3 <= stage2;
      sync_o <= (stage3 & ~differ) | (sync_o & differ);
    end
  end

endmodule : tsr_pin_sync

// ===== verilog/tsr_source_mux.sv
/*
  One source selector for one routed timing signal.
  Assumes all sources are already in the core clock domain.
*/
`timescale 1ns/1ps
module tsr_source_mux #(
  parameter int NSRC = 21,
  parameter int SEL_W = 5
) (
  // Sources
  input wire logic [NSRC-1:0] src_i,
  input wire logic [SEL_W-1:0] sel_i,
  // Result
  output logic sel_out_o
);

  if (NSRC > (1 << SEL_W)) begin : g_chk
    $error("tsr_source_mux: select too narrow");
  end

  // Codes past the last source read as low
  wire logic in_range = (32'(sel_i) < NSRC);
  assign sel_out_o = in_range ? src_i[sel_i] : 1'b0;

endmodule : tsr_source_mux

// ===== verilog/tsr_router.sv
/*
  Timing signal router: source selectors, function pin and trigger-bus
  drivers, timebase selection, general digital lines, reference and
  reglitch bits, with a plain register port.
  Assumes pins arrive asynchronously and are resolved outside from the
  active-low enables; counters and sequencer sit elsewhere.
*/
// The implementer's own choices: the register addresses and the address-and-strobe port.
// Operation
// - Eight general digital lines, each set input or output by software.
// - After reset every general digital line driver is off.
// - Digital lines six and seven feed counter zero and one up/down.
// - Up/down taps only sample the lines, never drive or change them.
// - Each of thirteen timing signals has its own programmed source selector.
// - Update strobe selector offers trigger lines, function pins, terminal count, counter zero.
// - All ten function pins feed every timing signal selector.
// - Several timing signals may pick one function pin at once.
// - Output-capable function pins have own enable, driving their dedicated signal.
// - Software picks internal oscillator or trigger-bus timebase.
// - Timebase drives onto trigger bus only while internal timebase selected.
// - Selected timebase directly paces all routing, no further selection stage; the code paces only selector updates, routed signals follow core clock.
// - Startup selects internal oscillator with bus timebase driver off.
// - Seven trigger lines each drive or receive one of five signals.
// - Per-channel reference select bit, default internal reference.
// - Per-channel reglitch enable bit, default off.
// - Function pins 0, 1, 2 and 7 never drive.
// - Driven update strobe marks each update with a falling edge.
// - Driven waveform start trigger rises at sequence start.
`timescale 1ns/1ps
module tsr_router (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic srst_i,
  // Register port
  input wire logic [tsr_pkg::TSR_ADDR_W-1:0] reg_addr_i,
  input wire logic [tsr_pkg::TSR_DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [tsr_pkg::TSR_DATA_W-1:0] reg_rdata_o,
  // General digital lines
  input wire logic [tsr_pkg::TSR_NUM_DIO-1:0] general_digital_line_i,
  output logic [tsr_pkg::TSR_NUM_DIO-1:0] general_digital_line_o,
  output logic [tsr_pkg::TSR_NUM_DIO-1:0] general_digital_line_oe_n_o,
  // Programmable function pins
  input wire logic [tsr_pkg::TSR_NUM_PFI-1:0] programmable_function_pin_i,
  output logic [tsr_pkg::TSR_NUM_PFI-1:0] programmable_function_pin_o,
  output logic [tsr_pkg::TSR_NUM_PFI-1:0] programmable_function_pin_oe_n_o,
  // Shared trigger lines
  input wire logic [tsr_pkg::TSR_NUM_TRIG-1:0] shared_trigger_line_i,
  output logic [tsr_pkg::TSR_NUM_TRIG-1:0] shared_trigger_line_o,
  output logic [tsr_pkg::TSR_NUM_TRIG-1:0] shared_trigger_line_oe_n_o,
  // Timebase
  input wire logic int_oscillator_i,
  input wire logic bus_timebase_i,
  output logic bus_timebase_o,
  output logic bus_timebase_oe_n_o,
  output logic timebase_tick_o,
  // Internal sources and routed signals
  input wire logic [tsr_pkg::TSR_NUM_INT-1:0] internal_source_i,
  output logic [tsr_pkg::TSR_NUM_SIG-1:0] routed_timing_o,
  // Counter up/down taps
  output logic counter0_updown_o,
  output logic counter1_updown_o,
  // Analog channel configuration
  output logic [tsr_pkg::TSR_NUM_CHAN-1:0] ref_select_ext_o,
  output logic [tsr_pkg::TSR_NUM_CHAN-1:0] reglitch_enable_o
);
  import tsr_pkg::*;

  // ==========================================================================
  // Elaboration checks
  if (TSR_CORE_CLK_MHZ < 4 * TSR_INT_TIMEBASE_MHZ) begin : g_chk_clk
    $error("tsr_router: core clock too slow to sample the timebase");
  end
  if (TSR_NUM_SIG > 16) begin : g_chk_sig
    $error("tsr_router: selector window holds sixteen entries");
  end

  // ==========================================================================
  // Functions
  function automatic logic bus_signal(input logic [TSR_NUM_SIG-1:0] sig,
                                      input logic [TSR_TSEL_W-1:0] code);
    bus_signal = (32'(code) < TSR_NUM_BUS_SIG) ? sig[code] : 1'b0;
  endfunction : bus_signal

  function automatic logic is_reg(input logic [TSR_ADDR_W-1:0] addr,
                                  input logic [7:0] offset);
    is_reg = (addr == offset);
  endfunction : is_reg

  // ==========================================================================
  // Registers
  logic [1:0] ctrl;
  logic [TSR_NUM_DIO-1:0] dio_dir;
  logic [TSR_NUM_DIO-1:0] dio_out;
  logic [TSR_NUM_PFI-1:0] pfi_oe;
  logic [TSR_NUM_TRIG-1:0] trig_oe;
  logic [TSR_NUM_TRIG-1:0][TSR_TSEL_W-1:0] trig_sel;
  logic [TSR_NUM_SIG-1:0][TSR_SEL_W-1:0] sel_shadow;
  logic [TSR_NUM_SIG-1:0][TSR_SEL_W-1:0] sel_active;
  logic [TSR_NUM_SIG-1:0] routed;
  logic tb_prev;

  // ==========================================================================
  // Pin synchronisers
  logic [TSR_NUM_DIO-1:0] dio_sync;
  logic [TSR_NUM_PFI-1:0] pfi_sync;
  logic [TSR_NUM_TRIG-1:0] trig_sync;
  logic [1:0] tb_sync;

  tsr_pin_sync #(.WIDTH(TSR_NUM_DIO)) u_sync_dio (
    .core_clk_i(core_clk_i),
    .srst_i(srst_i),
    .async_i(general_digital_line_i),
    .sync_o(dio_sync)
  );
  tsr_pin_sync #(.WIDTH(TSR_NUM_PFI)) u_sync_pfi (
    .core_clk_i(core_clk_i),
    .srst_i(srst_i),
    .async_i(programmable_function_pin_i),
    .sync_o(pfi_sync)
  );
  tsr_pin_sync #(.WIDTH(TSR_NUM_TRIG)) u_sync_trig (
    .core_clk_i(core_clk_i),
    .srst_i(srst_i),
    .async_i(shared_trigger_line_i),
    .sync_o(trig_sync)
  );
  tsr_pin_sync #(.WIDTH(2)) u_sync_tb (
    .core_clk_i(core_clk_i),
    .srst_i(srst_i),
    .async_i({bus_timebase_i, int_oscillator_i}),
    .sync_o(tb_sync)
  );

  // ==========================================================================
  // Decode
  wire logic tb_sel_bus = ctrl[TSR_CTRL_TB_SEL_BIT];
  wire logic tb_drive = ctrl[TSR_CTRL_TB_DRIVE_BIT];
  wire logic wr_ctrl = reg_wr_i && is_reg(reg_addr_i, TSR_OFF_CTRL);
  wire logic wr_dio_dir = reg_wr_i && is_reg(reg_addr_i, TSR_OFF_DIO_DIR);
  wire logic wr_dio_out = reg_wr_i && is_reg(reg_addr_i, TSR_OFF_DIO_OUT);
  wire logic wr_pfi_oe = reg_wr_i && is_reg(reg_addr_i, TSR_OFF_PFI_OE);
  wire logic wr_trig_oe = reg_wr_i && is_reg(reg_addr_i, TSR_OFF_TRIG_OE);
  wire logic wr_trig_sel = reg_wr_i && is_reg(reg_addr_i, TSR_OFF_TRIG_SEL);
  wire logic wr_ref = reg_wr_i && is_reg(reg_addr_i, TSR_OFF_REF_SEL);
  wire logic wr_reglitch = reg_wr_i && is_reg(reg_addr_i, TSR_OFF_REGLITCH);
  wire logic src_window = (reg_addr_i[7:6] == TSR_OFF_SRC_BASE[7:6])
                          && (reg_addr_i[1:0] == 2'h0);
  wire logic [3:0] src_idx = reg_addr_i[5:2];
  wire logic src_hit = src_window && (32'(src_idx) < TSR_NUM_SIG);

  // ==========================================================================
  // Timebase selection and tick
  wire logic tb_level = tb_sel_bus ? tb_sync[1] : tb_sync[0];
  // Rising edge of the chosen timebase paces selector updates; routed signals follow every core clock
  wire logic tb_tick = tb_level & ~tb_prev;
  wire logic tb_drive_ok = tb_drive && (tb_sel_bus == TSR_TB_INTERNAL);

  // ==========================================================================
  // Source selection
  wire logic [TSR_NUM_SRC-1:0] all_src = {internal_source_i, pfi_sync, trig_sync};
  logic [TSR_NUM_SIG-1:0] next_routed;

  // Independent muxes: one pin may feed any number of signals
  for (genvar g = 0; g < TSR_NUM_SIG; g++) begin : g_mux
    tsr_source_mux #(.NSRC(TSR_NUM_SRC), .SEL_W(TSR_SEL_W)) u_mux (
      .src_i(all_src),
      .sel_i(sel_active[g]),
      .sel_out_o(next_routed[g])
    );
  end

  // ==========================================================================
  // Pin drive values
  wire logic [TSR_NUM_PFI-1:0] pfi_oe_eff = pfi_oe & TSR_PFI_OUT_CAPABLE;
  wire logic [TSR_NUM_PFI-1:0] pfi_val = {
    routed[TSR_SIG_C0_GATE],
    routed[TSR_SIG_C0_SRC],
    1'b0,
    routed[TSR_SIG_WAVE_START],
    ~routed[TSR_SIG_UPDATE],
    routed[TSR_SIG_C1_GATE],
    routed[TSR_SIG_C1_SRC],
    3'h0
  };
  logic [TSR_NUM_TRIG-1:0] trig_val;
  always_comb begin
    for (int l = 0; l < TSR_NUM_TRIG; l++) begin
      trig_val[l] = bus_signal(routed, trig_sel[l]);
    end
  end

  // ==========================================================================
  // Read path
  logic [TSR_DATA_W-1:0] rd_value;
  always_comb begin
    rd_value = '0;
    if (is_reg(reg_addr_i, TSR_OFF_CTRL)) rd_value[1:0] = ctrl;
    if (is_reg(reg_addr_i, TSR_OFF_DIO_DIR)) rd_value[7:0] = dio_dir;
    if (is_reg(reg_addr_i, TSR_OFF_DIO_OUT)) rd_value[7:0] = dio_out;
    if (is_reg(reg_addr_i, TSR_OFF_DIO_IN)) rd_value[7:0] = dio_sync;
    if (is_reg(reg_addr_i, TSR_OFF_PFI_OE)) rd_value[9:0] = pfi_oe_eff;
    if (is_reg(reg_addr_i, TSR_OFF_TRIG_OE)) rd_value[6:0] = trig_oe;
    if (is_reg(reg_addr_i, TSR_OFF_TRIG_SEL)) rd_value[20:0] = trig_sel;
    if (is_reg(reg_addr_i, TSR_OFF_REF_SEL)) rd_value[7:0] = ref_select_ext_o;
    if (is_reg(reg_addr_i, TSR_OFF_REGLITCH)) rd_value[7:0] = reglitch_enable_o;
    if (is_reg(reg_addr_i, TSR_OFF_STATUS)) rd_value[15:0] = {tb_level, 2'h0, routed};
    if (src_hit) rd_value[4:0] = sel_shadow[src_idx];
  end

  // ==========================================================================
  // Configuration registers
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      ctrl <= TSR_RST_CTRL;
      dio_dir <= TSR_RST_DIO_DIR;
      dio_out <= TSR_RST_DIO_OUT;
      pfi_oe <= TSR_RST_PFI_OE;
      trig_oe <= TSR_RST_TRIG_OE;
      trig_sel <= TSR_RST_TRIG_SEL;
      ref_select_ext_o <= TSR_RST_REF_SEL;
      reglitch_enable_o <= TSR_RST_REGLITCH;
    end else begin
      if (wr_ctrl) ctrl <= reg_wdata_i[1:0];
      if (wr_dio_dir) dio_dir <= reg_wdata_i[7:0];
      if (wr_dio_out) dio_out <= reg_wdata_i[7:0];
      if (wr_pfi_oe) pfi_oe <= reg_wdata_i[9:0];
      if (wr_trig_oe) trig_oe <= reg_wdata_i[6:0];
      if (wr_trig_sel) trig_sel <= reg_wdata_i[20:0];
      if (wr_ref) ref_select_ext_o <= reg_wdata_i[7:0];
      if (wr_reglitch) reglitch_enable_o <= reg_wdata_i[7:0];
    end
  end

  // Shadow written by software, copied to the live selectors on a tick
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      sel_shadow <= {TSR_NUM_SIG{TSR_RST_SRC_SEL}};
      sel_active <= {TSR_NUM_SIG{TSR_RST_SRC_SEL}};
    end else begin
      if (reg_wr_i && src_hit) sel_shadow[src_idx] <= reg_wdata_i[4:0];
      if (tb_tick) sel_active <= sel_shadow;
    end
  end

  // ==========================================================================
  // Routed signals and pins
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      tb_prev <= 1'b0;
      routed <= '0;
      routed_timing_o <= '0;
      timebase_tick_o <= 1'b0;
    end else begin
      tb_prev <= tb_level;
      routed <= next_routed;
      routed_timing_o <= next_routed;
      timebase_tick_o <= tb_tick;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      general_digital_line_o <= '0;
      general_digital_line_oe_n_o <= '1;
      // Pin five idles high, as the inverted update strobe does
      programmable_function_pin_o <= TSR_RST_PFI_OUT;
      programmable_function_pin_oe_n_o <= '1;
      shared_trigger_line_o <= '0;
      shared_trigger_line_oe_n_o <= '1;
      bus_timebase_o <= 1'b0;
      bus_timebase_oe_n_o <= 1'b1;
      counter0_updown_o <= 1'b0;
      counter1_updown_o <= 1'b0;
      reg_rdata_o <= '0;
    end else begin
      general_digital_line_o <= dio_out;
      general_digital_line_oe_n_o <= ~dio_dir;
      programmable_function_pin_o <= pfi_val;
      programmable_function_pin_oe_n_o <= ~pfi_oe_eff;
      shared_trigger_line_o <= trig_val;
      shared_trigger_line_oe_n_o <= ~trig_oe;
      bus_timebase_o <= tb_sync[0];
      bus_timebase_oe_n_o <= ~tb_drive_ok;
      // Taps read the filtered lines only; direction logic never sees them
      counter0_updown_o <= dio_sync[6];
      counter1_updown_o <= dio_sync[7];
      reg_rdata_o <= reg_rd_i ? rd_value : '0;
    end
  end

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (srst_i);

  a_dio_dir_write: assert property (wr_dio_dir |-> ##2
    general_digital_line_oe_n_o == ~$past(reg_wdata_i[7:0], 2))
    else $error("digital line direction not applied");
  a_dio_reset_off: assert property (@(posedge core_clk_i) disable iff (1'b0)
    $past(srst_i) |-> (&general_digital_line_oe_n_o))
    else $error("digital line driven after reset");
  a_updown_tap: assert property ((counter0_updown_o == $past(dio_sync[6]))
    && (counter1_updown_o == $past(dio_sync[7])))
    else $error("up/down tap mismatch");
  a_tap_no_effect: assert property (!$past(wr_dio_dir, 2) |->
    $stable(general_digital_line_oe_n_o) || $past(srst_i, 2))
    else $error("digital line direction moved without a write");
  a_pfi_route_sel: assert property (
    $past(sel_active[TSR_SIG_UPDATE]) == TSR_SRC_PFI_BASE + 5'h4 |->
    routed[TSR_SIG_UPDATE] == $past(pfi_sync[4]))
    else $error("function pin not routed to update strobe");
  a_tc_route_sel: assert property (
    $past(sel_active[TSR_SIG_UPDATE]) == TSR_SRC_INT_BASE |->
    routed[TSR_SIG_UPDATE] == $past(internal_source_i[TSR_INT_SAMPLE_TC]))
    else $error("terminal count not routed to update strobe");
  a_pfi_input_only: assert property (@(posedge core_clk_i)
    programmable_function_pin_oe_n_o[0] && programmable_function_pin_oe_n_o[1]
    && programmable_function_pin_oe_n_o[2] && programmable_function_pin_oe_n_o[7])
    else $error("input-only function pin driven");
  a_tb_drive_gate: assert property (!bus_timebase_oe_n_o |->
    $past(tb_drive) && !$past(tb_sel_bus))
    else $error("timebase driven while bus timebase selected");
  a_sel_on_tick: assert property (!$past(tb_tick) |-> $stable(sel_active))
    else $error("selector changed off a timebase edge");
  a_update_falling: assert property (
    programmable_function_pin_o[5] == ~$past(routed[TSR_SIG_UPDATE]))
    else $error("update strobe polarity wrong on pin");
  a_wave_rising: assert property (
    programmable_function_pin_o[6] == $past(routed[TSR_SIG_WAVE_START]))
    else $error("waveform start trigger polarity wrong on pin");
  a_cfg_defaults: assert property (@(posedge core_clk_i) disable iff (1'b0)
    $past(srst_i) |-> (ref_select_ext_o == '0) && (reglitch_enable_o == '0)
    && bus_timebase_oe_n_o && (&shared_trigger_line_oe_n_o))
    else $error("configuration not at defaults after reset");

  c_tick: cover property (tb_tick ##[1:20] tb_tick);
  c_trig_drive: cover property (!shared_trigger_line_oe_n_o[0]);
  c_update_pin: cover property (!programmable_function_pin_oe_n_o[5]);
  c_tb_out: cover property (!bus_timebase_oe_n_o);

endmodule : tsr_router

// ===== tb/tsr_far_side.sv
/*
  Far side model: external circuitry on the function pins and digital lines,
  other boards on the trigger bus and bus timebase, and the local oscillator.
  Assumes active-low enables from the router; the bench sets what is driven.
*/
`timescale 1ns/1ps
module tsr_far_side (
  // Clock
  input wire logic core_clk_i,
  // Device side
  input wire logic [9:0] dev_pin_i,
  input wire logic [9:0] dev_pin_oe_n_i,
  input wire logic [6:0] dev_trig_i,
  input wire logic [6:0] dev_trig_oe_n_i,
  input wire logic [7:0] dev_dio_i,
  input wire logic [7:0] dev_dio_oe_n_i,
  input wire logic dev_tb_i,
  input wire logic dev_tb_oe_n_i,
  // Bench control
  input wire logic [9:0] ext_pin_i,
  input wire logic [9:0] ext_pin_en_i,
  input wire logic [6:0] ext_trig_i,
  input wire logic [7:0] ext_dio_i,
  input wire logic [7:0] ext_dio_en_i,
  input wire logic osc_run_i,
  input wire logic board_clk_en_i,
  // Resolved wires
  output logic [9:0] pin_o,
  output logic [6:0] trig_o,
  output logic [7:0] dio_o,
  output logic osc_o,
  output logic tb_o
);
  logic osc = 1'b0;
  logic brd = 1'b0;
  logic flip = 1'b0;
  initial forever #25 osc = ~osc;
  initial forever #40 brd = ~brd;
  always @(posedge core_clk_i) flip <= ~flip;
  assign osc_o = osc & osc_run_i;
  // Pin 0 pulled down, the rest pulled up when nobody drives
  assign pin_o = (~dev_pin_oe_n_i & dev_pin_i) | (dev_pin_oe_n_i & ext_pin_en_i & ext_pin_i)
    | (dev_pin_oe_n_i & ~ext_pin_en_i & 10'h3fe);
  assign dio_o = (~dev_dio_oe_n_i & dev_dio_i) | (dev_dio_oe_n_i & ext_dio_en_i & ext_dio_i)
    | (dev_dio_oe_n_i & ~ext_dio_en_i);
  // Other boards drive every trigger line the device leaves free
  assign trig_o = (~dev_trig_oe_n_i & dev_trig_i) | (dev_trig_oe_n_i & ext_trig_i);
  // Undriven timebase line has no pull, so it wanders
  assign tb_o = !dev_tb_oe_n_i ? dev_tb_i : (board_clk_en_i ? brd : flip);
endmodule : tsr_far_side

// ===== tb/tb_timing_signal_router.sv
/*
  Self-checking bench for the router: register calls with expected values.
  Assumes the far side model resolves every pin from the router's enables.
*/
`timescale 1ns/1ps
module tb_timing_signal_router;
  import tsr_pkg::*;
  logic clk, srst, wr, rd, osc, tb_in, tb_o, tb_oe_n, tick, up0, up1, osc_run, brd_en;
  logic [7:0] addr, dio_o, dio_oe_n, dio_w, ext_dio, ext_dio_en, ref_ext, reglitch;
  logic [31:0] wdata, rdata, rv;
  logic [9:0] pin_o, pin_oe_n, pin_w, ext_pin, ext_pin_en;
  logic [6:0] trig_o, trig_oe_n, trig_w, ext_trig;
  logic [3:0] isrc;
  logic [12:0] routed;
  logic [7:0] offs [9] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h14, 8'h1c, 8'h20, 8'h18, 8'h40};
  logic [31:0] exps [9] = '{0, 0, 0, 0, 0, 0, 0, 32'h1fffff, 32'h1f};
  int err_total = 0;
  int n_compared = 0;
  int cyc = 0;
  tsr_router i_dut (.core_clk_i(clk), .srst_i(srst), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .general_digital_line_i(dio_w),
    .general_digital_line_o(dio_o), .general_digital_line_oe_n_o(dio_oe_n),
    .programmable_function_pin_i(pin_w), .programmable_function_pin_o(pin_o),
    .programmable_function_pin_oe_n_o(pin_oe_n), .shared_trigger_line_i(trig_w),
    .shared_trigger_line_o(trig_o), .shared_trigger_line_oe_n_o(trig_oe_n),
    .int_oscillator_i(osc), .bus_timebase_i(tb_in), .bus_timebase_o(tb_o),
    .bus_timebase_oe_n_o(tb_oe_n), .timebase_tick_o(tick), .internal_source_i(isrc),
    .routed_timing_o(routed), .counter0_updown_o(up0), .counter1_updown_o(up1),
    .ref_select_ext_o(ref_ext), .reglitch_enable_o(reglitch));
  tsr_far_side i_far (.core_clk_i(clk), .dev_pin_i(pin_o), .dev_pin_oe_n_i(pin_oe_n),
    .dev_trig_i(trig_o), .dev_trig_oe_n_i(trig_oe_n), .dev_dio_i(dio_o),
    .dev_dio_oe_n_i(dio_oe_n), .dev_tb_i(tb_o), .dev_tb_oe_n_i(tb_oe_n), .ext_pin_i(ext_pin),
    .ext_pin_en_i(ext_pin_en), .ext_trig_i(ext_trig), .ext_dio_i(ext_dio),
    .ext_dio_en_i(ext_dio_en), .osc_run_i(osc_run), .board_clk_en_i(brd_en), .pin_o(pin_w),
    .trig_o(trig_w), .dio_o(dio_w), .osc_o(osc), .tb_o(tb_in));
  // ==========================================================================
  // Tasks
  task automatic summarize();
    if (err_total == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : summarize
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : wait_cyc
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg
  // ==========================================================================
  // Clock and timeout
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Whole run needs roughly 1240 cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      summarize();
    end
  end
  // ==========================================================================
  // Sequence
  initial begin
    {wr, rd, addr, wdata, ext_dio, ext_dio_en, ext_pin, ext_trig, isrc, brd_en} = '0;
    ext_pin_en = 10'h3ff;
    osc_run = 1'b1;
    srst = 1'b1;
    wait_cyc(6);
    srst <= 1'b0;
    for (int k = 0; k < 9; k++) begin
      rd_reg(offs[k], rv);
      chk("reset value", rv, exps[k]);
    end
    chk("enables", {6'h0, dio_oe_n, pin_oe_n, trig_oe_n, tb_oe_n}, 32'h3ffffff);
    chk("channel bits", {ref_ext, reglitch}, 0);
    wr_reg(TSR_OFF_REF_SEL, 32'h81);
    wr_reg(TSR_OFF_REGLITCH, 32'h42);
    wr_reg(TSR_OFF_DIO_DIR, 32'ha5);
    wr_reg(TSR_OFF_DIO_OUT, 32'h3c);
    ext_dio <= 8'h5a;
    ext_dio_en <= 8'hff;
    wait_cyc(8);
    chk("channel bits", {ref_ext, reglitch}, 32'h8142);
    chk("dio drive", {dio_oe_n, dio_o}, 32'h5a3c);
    rd_reg(TSR_OFF_DIO_IN, rv);
    chk("dio in", rv, 32'h7e);
    chk("updown taps", {up1, up0}, 32'h1);
    chk("dio dir kept", dio_oe_n, 32'h5a);
    wr_reg(8'h30, 32'hffffffff);
    rd_reg(8'h30, rv);
    chk("unmapped", rv, 0);
    for (int c = 0; c < 19; c++) begin
      ext_trig <= (c < 7) ? 7'(1 << c) : 7'h0;
      ext_pin <= (c >= 7 && c < 17) ? 10'(1 << (c - 7)) : 10'h0;
      isrc <= (c >= 17) ? 4'(1 << (c - 17)) : 4'h0;
      wr_reg(TSR_OFF_SRC_BASE + 8'(4 * (c % 13)), 32'(c));
      wr_reg(TSR_OFF_SRC_BASE, 32'(c));
      wait_cyc(40);
      chk("routed source", 32'(routed), 32'(1 << (c % 13)) | 32'h1);
      wr_reg(TSR_OFF_SRC_BASE + 8'(4 * (c % 13)), 32'h1f);
    end
    // Stopped oscillator gives no tick, so new selections must wait
    osc_run <= 1'b0;
    {ext_trig, isrc} <= '0;
    ext_pin <= 10'h001;
    wait_cyc(20);
    wr_reg(TSR_OFF_SRC_BASE, 32'h07);
    wr_reg(TSR_OFF_SRC_BASE + 8'h08, 32'h07);
    wait_cyc(30);
    chk("held selection", 32'(routed), 0);
    chk("quiet timebase", {tick, tb_o}, 0);
    osc_run <= 1'b1;
    wait_cyc(40);
    chk("shared pin", 32'(routed), 32'h5);
    wr_reg(TSR_OFF_PFI_OE, 32'h3ff);
    rd_reg(TSR_OFF_PFI_OE, rv);
    chk("pin enable read", rv, 32'h378);
    wr_reg(TSR_OFF_SRC_BASE + 8'h04, 32'h07);
    wait_cyc(40);
    chk("pin enables", pin_oe_n, 32'h087);
    chk("pin outputs", pin_o & 10'h378, 32'h140);
    ext_pin <= 10'h000;
    wait_cyc(40);
    chk("pin outputs", pin_o & 10'h378, 32'h020);
    ext_pin <= 10'h001;
    wr_reg(TSR_OFF_TRIG_SEL, 32'h44688);
    wr_reg(TSR_OFF_TRIG_OE, 32'h7f);
    wait_cyc(40);
    chk("trigger lines", {trig_oe_n, trig_o}, 32'h0067);
    wr_reg(TSR_OFF_CTRL, 32'h2);
    wait_cyc(3);
    chk("timebase drive", tb_oe_n, 0);
    wr_reg(TSR_OFF_CTRL, 32'h3);
    wait_cyc(3);
    chk("timebase drive", tb_oe_n, 1);
    wr_reg(TSR_OFF_CTRL, 32'h1);
    osc_run <= 1'b0;
    brd_en <= 1'b1;
    wait_cyc(20);
    wr_reg(TSR_OFF_SRC_BASE + 8'h0c, 32'h07);
    wait_cyc(60);
    chk("bus timebase", routed[3], 1);
    summarize();
  end
endmodule : tb_timing_signal_router
